// *** verilog/sscc_defines.svh ***
// Purpose: offsets, field positions and reset values of the stream channel registers
// Assumes: APB byte addresses, one 32-bit word per register
// Notes: printed offsets are not all multiples of four, so they are word indices
`ifndef SSCC_DEFINES_SVH
`define SSCC_DEFINES_SVH
`define SSCC_IDX_PAT2_LO 6'h1B
`define SSCC_IDX_PAT2_HI 6'h1C
`define SSCC_IDX_FMT 6'h21
`define SSCC_IDX_LANE 6'h22
`define SSCC_IDX_CHSEL 6'h30
`define SSCC_RST_PAT2 8'h00
`define SSCC_RST_FMT 8'h00
`define SSCC_RST_LANE 8'h00
`define SSCC_RST_CHSEL 8'h0F
`define SSCC_FMT_LSB_FIRST 7
`define SSCC_FMT_LOW_RATE 3
`define SSCC_FMT_RES_LO 0
`define SSCC_FMT_MASK 8'h8F
`define SSCC_LANE_OUT_RST 1
`define SSCC_LANE_PDN 0
`define SSCC_LANE_MASK 8'h03
`define SSCC_CHSEL_MASK 8'h0F
`define SSCC_NUM_CH 4
`endif

// *** verilog/sscc_pkg.sv ***
// Purpose: types of the stream channel register bank
// Assumes: four converter channels
// Notes: constants live in sscc_defines.svh
package sscc_pkg;
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [31:0] paddr;
		logic [31:0] pwdata;
	} sscc_apb_req_t;
	typedef struct packed {
		logic [7:0] pat2_lo;
		logic [7:0] pat2_hi;
		logic [7:0] fmt;
		logic [3:0] chsel;
		logic [3:0] out_rst;
		logic [3:0] pdn;
		logic pslverr;
		logic [31:0] prdata;
	} sscc_state_t;
endpackage

// *** verilog/sscc_res_decode.sv ***
// Purpose: decode of the output word resolution code
// Assumes: three-bit code from the stream format register
// Notes: unlisted codes fall back to the native length
`timescale 1ns/100ps
module sscc_res_decode (
	// Code in
	input wire logic [2:0] res_code,
	// Length out
	output logic [3:0] word_bits
);
	always_comb begin
		unique case (res_code)
			3'h1: word_bits = 4'h8;
			3'h3: word_bits = 4'hC;
			3'h4: word_bits = 4'hE;
			default: word_bits = 4'hA;
		endcase
	end
endmodule

// *** verilog/sscc_top.sv ***
// Purpose: APB register bank for serial stream and per-channel controls
// Assumes: zero-wait APB slave, byte address = 4 x index
// Notes: channel select register decides which lanes a lane write reaches
//
// Local design decision: the APB register port.
`timescale 1ns/100ps
`include "sscc_defines.svh"
// Operation
// [R1] Low byte of second test pattern at index 1B, resets to zero.
// [R2] High byte of second test pattern at index 1C, resets to zero.
// [R3] Stream control bit 7 set sends LSB first; clear sends MSB first.
// [R4] Stream control bit 3 enables low encode-rate mode, off at reset.
// [R5] Resolution code: 000/010 ten bits, 001 eight, 011 twelve, 100 fourteen.
// [R6] Lane bit 1 holds selected channels' output logic in reset.
// [R7] Lane bit 0 powers down selected channels individually, clear at reset.
// [R8] Unused bits read zero; writes to them have no effect.
module sscc_top (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Stream controls
	output logic [15:0] pattern_two,
	output logic lsb_first,
	output logic low_rate_mode,
	output logic [3:0] word_bits,
	// Per-channel controls
	output logic [3:0] ch_out_reset,
	output logic [3:0] ch_power_down
);
	sscc_pkg::sscc_state_t state_ff;
	sscc_pkg::sscc_state_t nxt_state;
	logic [5:0] idx;
	logic [7:0] wbyte;
	logic wr;
	logic rd;
	logic hit;
	logic [7:0] lane_rd;

	assign idx = paddr[7:2];
	assign wbyte = pwdata[7:0];
	assign wr = psel && penable && pwrite;
	assign rd = psel && penable && !pwrite;
	assign hit = (paddr[31:8] == 24'h000000) && (paddr[1:0] == 2'h0) &&
		(idx == `SSCC_IDX_PAT2_LO || idx == `SSCC_IDX_PAT2_HI ||
		idx == `SSCC_IDX_FMT || idx == `SSCC_IDX_LANE || idx == `SSCC_IDX_CHSEL);
	// Readback shows the lowest selected channel's lane bits
	always_comb begin
		lane_rd = 8'h00;
		for (int i = `SSCC_NUM_CH - 1; i >= 0; i--) begin
			if (state_ff.chsel[i]) begin
				lane_rd = {6'h00, state_ff.out_rst[i], state_ff.pdn[i]};
			end
		end
	end

	always_comb begin
		nxt_state = state_ff;
		nxt_state.pslverr = 1'b0;
		nxt_state.prdata = 32'h00000000;
		if (psel && !penable) begin
			nxt_state.pslverr = !hit;
			if (!pwrite && hit) begin
				unique case (idx)
					`SSCC_IDX_PAT2_LO: nxt_state.prdata = {24'h000000, state_ff.pat2_lo}; // [R1]
					`SSCC_IDX_PAT2_HI: nxt_state.prdata = {24'h000000, state_ff.pat2_hi}; // [R2]
					`SSCC_IDX_FMT: nxt_state.prdata = {24'h000000, state_ff.fmt};
					`SSCC_IDX_LANE: nxt_state.prdata = {24'h000000, lane_rd};
					default: nxt_state.prdata = {28'h0000000, state_ff.chsel}; // [R8]
				endcase
			end
		end else if (psel && penable) begin
			nxt_state.pslverr = state_ff.pslverr;
			nxt_state.prdata = state_ff.prdata;
		end
		if (wr && hit) begin
			unique case (idx)
				`SSCC_IDX_PAT2_LO: nxt_state.pat2_lo = wbyte; // [R1]
				`SSCC_IDX_PAT2_HI: nxt_state.pat2_hi = wbyte; // [R2]
				`SSCC_IDX_FMT: nxt_state.fmt = wbyte & `SSCC_FMT_MASK; // [R8]
				`SSCC_IDX_LANE: begin
					for (int i = 0; i < `SSCC_NUM_CH; i++) begin
						if (state_ff.chsel[i]) begin
							nxt_state.out_rst[i] = wbyte[`SSCC_LANE_OUT_RST]; // [R6]
							nxt_state.pdn[i] = wbyte[`SSCC_LANE_PDN]; // [R7]
						end
					end
				end
				default: nxt_state.chsel = wbyte[3:0];
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_ff.pat2_lo <= `SSCC_RST_PAT2;
			state_ff.pat2_hi <= `SSCC_RST_PAT2;
			state_ff.fmt <= `SSCC_RST_FMT;
			state_ff.chsel <= 4'(`SSCC_RST_CHSEL);
			state_ff.out_rst <= 4'(`SSCC_RST_LANE);
			state_ff.pdn <= 4'(`SSCC_RST_LANE);
			state_ff.pslverr <= 1'b0;
			state_ff.prdata <= 32'h00000000;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// Read data is captured in setup so access completes with no wait state
	assign pready = 1'b1;
	assign prdata = state_ff.prdata;
	assign pslverr = state_ff.pslverr && psel && penable;
	assign pattern_two = {state_ff.pat2_hi, state_ff.pat2_lo};
	assign lsb_first = state_ff.fmt[`SSCC_FMT_LSB_FIRST]; // [R3]
	assign low_rate_mode = state_ff.fmt[`SSCC_FMT_LOW_RATE]; // [R4]
	assign ch_out_reset = state_ff.out_rst; // [R6]
	assign ch_power_down = state_ff.pdn; // [R7]

	sscc_res_decode u_res (
		.res_code(state_ff.fmt[2:0]), // [R5]
		.word_bits(word_bits)
	);

	property p_fmt_write;
		@(posedge pclk) disable iff (!presetn)
		(wr && hit && idx == `SSCC_IDX_FMT) |=> (lsb_first == $past(pwdata[7]) &&
			low_rate_mode == $past(pwdata[3]));
	endproperty
	a_fmt_write: assert property (p_fmt_write) else $error("format write lost"); // [R3]

	property p_low_rate_hold;
		@(posedge pclk) disable iff (!presetn)
		!(wr && idx == `SSCC_IDX_FMT) |=> $stable(low_rate_mode);
	endproperty
	a_low_rate_hold: assert property (p_low_rate_hold) else $error("low rate moved"); // [R4]

	property p_res;
		@(posedge pclk) disable iff (!presetn)
		(state_ff.fmt[2:0] == 3'h3) |-> (word_bits == 4'hC);
	endproperty
	a_res: assert property (p_res) else $error("resolution decode wrong"); // [R5]

	property p_pat_lo;
		@(posedge pclk) disable iff (!presetn)
		(wr && hit && idx == `SSCC_IDX_PAT2_LO) |=> (pattern_two[7:0] == $past(pwdata[7:0]));
	endproperty
	a_pat_lo: assert property (p_pat_lo) else $error("pattern low not stored"); // [R1]

	property p_pat_hi;
		@(posedge pclk) disable iff (!presetn)
		(wr && hit && idx == `SSCC_IDX_PAT2_HI) |=> (pattern_two[15:8] == $past(pwdata[7:0]));
	endproperty
	a_pat_hi: assert property (p_pat_hi) else $error("pattern high not stored"); // [R2]

	property p_ch_rst;
		@(posedge pclk) disable iff (!presetn)
		(wr && hit && idx == `SSCC_IDX_LANE && state_ff.chsel[0]) |=>
			(ch_out_reset[0] == $past(pwdata[1]));
	endproperty
	a_ch_rst: assert property (p_ch_rst) else $error("channel reset not stored"); // [R6]

	property p_ch_pdn_local;
		@(posedge pclk) disable iff (!presetn)
		(wr && idx == `SSCC_IDX_LANE && !state_ff.chsel[1]) |=> $stable(ch_power_down[1]);
	endproperty
	a_ch_pdn_local: assert property (p_ch_pdn_local) else $error("unselected lane hit"); // [R7]

	property p_unused_zero;
		@(posedge pclk) disable iff (!presetn)
		(state_ff.fmt[6:4] == 3'h0) && (prdata[31:8] == 24'h000000);
	endproperty
	a_unused_zero: assert property (p_unused_zero) else $error("unused bits set"); // [R8]

	property p_lsb_hold;
		@(posedge pclk) disable iff (!presetn)
		!(wr && idx == `SSCC_IDX_FMT) |=> $stable(lsb_first);
	endproperty
	a_lsb_hold: assert property (p_lsb_hold) else $error("bit order moved"); // [R3]

	property p_res_eight;
		@(posedge pclk) disable iff (!presetn)
		(state_ff.fmt[2:0] == 3'h1) |-> (word_bits == 4'h8);
	endproperty
	a_res_eight: assert property (p_res_eight) else $error("eight bit decode wrong"); // [R5]

	property p_res_fourteen;
		@(posedge pclk) disable iff (!presetn)
		(state_ff.fmt[2:0] == 3'h4) |-> (word_bits == 4'hE);
	endproperty
	a_res_fourteen: assert property (p_res_fourteen) else $error("fourteen bit decode wrong"); // [R5]

	// Spare codes share the native length so software cannot pick a bad width
	property p_res_native;
		@(posedge pclk) disable iff (!presetn)
		(state_ff.fmt[2:0] inside {3'h0, 3'h2, 3'h5, 3'h6, 3'h7}) |-> (word_bits == 4'hA);
	endproperty
	a_res_native: assert property (p_res_native) else $error("native length decode wrong"); // [R5]

	property p_pat_lo_hold;
		@(posedge pclk) disable iff (!presetn)
		!(wr && idx == `SSCC_IDX_PAT2_LO) |=> $stable(pattern_two[7:0]);
	endproperty
	a_pat_lo_hold: assert property (p_pat_lo_hold) else $error("pattern low moved"); // [R1]

	property p_pat_hi_hold;
		@(posedge pclk) disable iff (!presetn)
		!(wr && idx == `SSCC_IDX_PAT2_HI) |=> $stable(pattern_two[15:8]);
	endproperty
	a_pat_hi_hold: assert property (p_pat_hi_hold) else $error("pattern high moved"); // [R2]

	property p_ch_pdn;
		@(posedge pclk) disable iff (!presetn)
		(wr && hit && idx == `SSCC_IDX_LANE && state_ff.chsel[1]) |=>
			(ch_power_down[1] == $past(pwdata[0]));
	endproperty
	a_ch_pdn: assert property (p_ch_pdn) else $error("channel power down not stored"); // [R7]

	property p_ch_rst_local;
		@(posedge pclk) disable iff (!presetn)
		(wr && idx == `SSCC_IDX_LANE && !state_ff.chsel[0]) |=> $stable(ch_out_reset[0]);
	endproperty
	a_ch_rst_local: assert property (p_ch_rst_local) else $error("unselected reset hit"); // [R6]

	property p_lane_read;
		@(posedge pclk) disable iff (!presetn)
		(psel && !penable && !pwrite && hit && idx == `SSCC_IDX_LANE && state_ff.chsel[0]) |=>
			(prdata == {30'h0000000, ch_out_reset[0], ch_power_down[0]});
	endproperty
	a_lane_read: assert property (p_lane_read) else $error("lane readback wrong"); // [R8]
endmodule

// *** tb/sscc_top_test.sv ***
// Purpose: self-checking bench for the stream channel register bank
// Assumes: zero-wait APB slave, byte address = 4 x index
// Notes: lane writes reach the channels chosen by the channel select register
`timescale 1ns/100ps
`include "sscc_defines.svh"
module sscc_top_test;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, lsb_first, low_rate_mode, err;
	logic [31:0] paddr, pwdata, prdata, rd;
	logic [15:0] pattern_two;
	logic [3:0] word_bits, ch_out_reset, ch_power_down;
	logic [3:0] wb [8] = '{4'hA, 4'h8, 4'hA, 4'hC, 4'hE, 4'hA, 4'hA, 4'hA};
	int fails, n_checks;
	sscc_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .pattern_two(pattern_two), .lsb_first(lsb_first),
		.low_rate_mode(low_rate_mode), .word_bits(word_bits), .ch_out_reset(ch_out_reset),
		.ch_power_down(ch_power_down));
	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end
	function automatic logic [31:0] ad(input logic [5:0] idx);
		return {24'h000000, idx, 2'b00};
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Read data and error are taken before that edge's updates land
	task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rdchk(input logic [31:0] a, input logic [31:0] exp, input logic e);
		apb(1'b0, a, 32'h00000000);
		chk(rd, exp);
		chk({31'h0, err}, {31'h0, e});
	endtask
	task automatic t_reset;
		rdchk(ad(`SSCC_IDX_PAT2_LO), 32'h00, 1'b0);
		rdchk(ad(`SSCC_IDX_PAT2_HI), 32'h00, 1'b0);
		rdchk(ad(`SSCC_IDX_FMT), 32'h00, 1'b0);
		rdchk(ad(`SSCC_IDX_LANE), 32'h00, 1'b0);
		chk({lsb_first, low_rate_mode, word_bits}, 6'h0A);
		chk({ch_out_reset, ch_power_down}, 8'h00);
	endtask
	// Stored bytes show only once the access edge has passed
	task automatic t_pattern;
		apb(1'b1, ad(`SSCC_IDX_PAT2_LO), 32'hFFFFFFA5);
		apb(1'b1, ad(`SSCC_IDX_PAT2_HI), 32'h0000003C);
		@(posedge pclk);
		chk(pattern_two, 16'h3CA5);
		rdchk(ad(`SSCC_IDX_PAT2_LO), 32'hA5, 1'b0);
		rdchk(ad(`SSCC_IDX_PAT2_HI), 32'h3C, 1'b0);
	endtask
	task automatic t_format;
		apb(1'b1, ad(`SSCC_IDX_FMT), 32'hFFFFFFFF);
		rdchk(ad(`SSCC_IDX_FMT), 32'h8F, 1'b0);
		chk(lsb_first, 1'b1);
		chk(low_rate_mode, 1'b1);
		for (int i = 0; i < 8; i++) begin
			apb(1'b1, ad(`SSCC_IDX_FMT), i);
			@(posedge pclk);
			chk(word_bits, wb[i]);
		end
		chk({lsb_first, low_rate_mode}, 2'b00);
	endtask
	task automatic t_lane;
		apb(1'b1, ad(`SSCC_IDX_CHSEL), 32'h2);
		apb(1'b1, ad(`SSCC_IDX_LANE), 32'hFF);
		@(posedge pclk);
		chk(ch_out_reset, 4'h2);
		chk(ch_power_down, 4'h2);
		rdchk(ad(`SSCC_IDX_LANE), 32'h03, 1'b0);
		apb(1'b1, ad(`SSCC_IDX_CHSEL), 32'hF);
		apb(1'b1, ad(`SSCC_IDX_LANE), 32'h1);
		@(posedge pclk);
		chk({ch_out_reset, ch_power_down}, 8'h0F);
	endtask
	// Refused accesses must not disturb a stored pattern
	task automatic t_refuse;
		rdchk(32'h00000004, 32'h0, 1'b1);
		apb(1'b1, ad(`SSCC_IDX_PAT2_LO) + 32'h1, 32'h11);
		chk(err, 1'b1);
		@(posedge pclk);
		chk(pattern_two, 16'h3CA5);
	endtask
	// Second reset must undo every write, channel select included
	task automatic t_rerun;
		apb(1'b1, ad(`SSCC_IDX_FMT), 32'h89);
		apb(1'b1, ad(`SSCC_IDX_CHSEL), 32'h1);
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		chk(pattern_two[7:0], 8'h00);
		chk(pattern_two[15:8], 8'h00);
		chk(lsb_first, 1'b0);
		chk(low_rate_mode, 1'b0);
		chk(word_bits, 4'hA);
		chk({ch_out_reset, ch_power_down}, 8'h00);
		apb(1'b1, ad(`SSCC_IDX_LANE), 32'h2);
		@(posedge pclk);
		chk(ch_out_reset, 4'hF);
	endtask
	task automatic end_sim;
		$display("checks %0d fails %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		{presetn, psel, penable, pwrite} = 4'h0;
		paddr = 32'h0;
		pwdata = 32'h0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_pattern();
		t_format();
		t_lane();
		t_refuse();
		t_rerun();
		end_sim();
	end
	// Whole run is about 120 cycles
	initial begin
		repeat (5000) @(posedge pclk);
		fails++;
		end_sim();
	end
endmodule
